/* nvm_pkg.sv */
// Shared constants and state encoding for the serial byte memory slave.
package nvm_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int          MEM_AW     = 16;
  localparam int          BYTE_W     = 8;
  localparam int          BIT_CNT_W  = 4;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  BIT_CNT_0  = 4'h0;
  localparam logic [3:0]  BIT_STEP   = 4'h1;

  // ****************************************************************
  // Field positions of the address byte
  // ****************************************************************
  localparam int          TYPE_MSB   = 7;
  localparam int          TYPE_LSB   = 4;
  localparam int          SEL_MSB    = 3;
  localparam int          SEL_LSB    = 1;
  localparam int          DIR_BIT    = 0;
  localparam logic        DIR_WRITE  = 1'b0;
  localparam logic        DIR_READ   = 1'b1;

  // ****************************************************************
  // Values after reset and pointer step
  // ****************************************************************
  localparam logic [15:0] PTR_RST    = 16'h0000;
  localparam logic [15:0] PTR_STEP   = 16'h0001;
  localparam logic [7:0]  BYTE_RST   = 8'h00;

  // ****************************************************************
  // Protocol states
  // ****************************************************************
  typedef enum logic [2:0] {
    NVM_IDLE = 3'b000,
    NVM_DEV  = 3'b001,
    NVM_AHI  = 3'b010,
    NVM_ALO  = 3'b011,
    NVM_WDAT = 3'b100,
    NVM_ACK  = 3'b101,
    NVM_RDAT = 3'b110,
    NVM_RACK = 3'b111
  } nvm_state_t;

endpackage

/* nvm_mem.sv */
// Byte array with one port and registered read data.
module nvm_mem #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          core_clk,
  // Access
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  // Read data
  output logic      [DW-1:0] rdata_r
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk)
  begin
    if (en && we)
    begin
      mem[addr] <= wdata;
    end
    if (en && !we)
    begin
      rdata_r <= mem[addr];
    end
  end

endmodule

/* nvm_slave.sv */
// Two-wire serial byte memory slave: protocol engine around the byte array.

// Function
// - Address byte carries type code then select bits 2, 1, 0 in order.
// - Respond only when received select bits equal the strapped select pins.
// - Eighth address bit is direction: 0 write, 1 read.
// - Wrong type code or select bits returns to standby for the transfer.
// - Matching address byte after start is acknowledged low on ninth clock.
// - Two memory address bytes follow, high first, each acknowledged low.
// - In a write each received byte is acknowledged before the next.
// - In a read eight bits are driven, then the line is released.
// - Never busy after a write; a new address byte is acknowledged at once.
// - Write protect high blocks all array writes; reads always allowed.
// - Further data bytes are stored at successive locations.
// - Write address wraps from the top location to zero.
// - Each data byte is committed when its acknowledge ends.
// - A read without address phase returns the location after the last one.
// - After the top location a current-address read returns location zero.
// - The pointer has no promised value before the first addressed access.
// - Random read uses a write address phase, repeated start, then read.
// - While the master acknowledges, successive bytes follow, wrapping to zero.
// - Bits are sampled on clock rise and driven on clock fall.
// - A stop before an acknowledge abandons the operation to standby.
module nvm_slave #(
  // Device type code; the default value is arbitrary.
  parameter logic [3:0] TYPE_CODE = 4'h5,
  parameter int         AW        = nvm_pkg::MEM_AW
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Serial bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Straps and protection
  input  wire logic select_pin_2,
  input  wire logic select_pin_1,
  input  wire logic select_pin_0,
  input  wire logic write_protect,
  // Status
  output logic      busy
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] nvm_inc(input logic [15:0] a);
    nvm_inc = a + nvm_pkg::PTR_STEP;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  nvm_pkg::nvm_state_t state_r;
  nvm_pkg::nvm_state_t state_nxt;
  nvm_pkg::nvm_state_t ret_r;
  nvm_pkg::nvm_state_t ret_nxt;
  logic [3:0]          bit_cnt_r;
  logic [3:0]          bit_cnt_nxt;
  logic [7:0]          rx_r;
  logic [7:0]          rx_nxt;
  logic [7:0]          tx_r;
  logic [7:0]          tx_nxt;
  logic [7:0]          wbuf_r;
  logic [7:0]          wbuf_nxt;
  logic [15:0]         ptr_r;
  logic [15:0]         ptr_nxt;
  logic                pend_r;
  logic                pend_nxt;
  logic                mack_r;
  logic                mack_nxt;
  logic                oe_r;
  logic                oe_nxt;
  logic                scl_q_r;
  logic                sda_q_r;
  logic                busy_r;
  logic                mem_en_r;
  logic                mem_en_nxt;
  logic                mem_we_r;
  logic                mem_we_nxt;
  logic [15:0]         mem_addr_r;
  logic [15:0]         mem_addr_nxt;
  logic [7:0]          mem_wdata_r;
  logic [7:0]          mem_wdata_nxt;
  logic [7:0]          mem_rdata;

  // ****************************************************************
  // Bus event decode
  // ****************************************************************
  wire       scl_rise  = scl_in & ~scl_q_r;
  wire       scl_fall  = ~scl_in & scl_q_r;
  wire       scl_high  = scl_in & scl_q_r;
  wire       start_det = scl_high & sda_q_r & ~sda_in;
  wire       stop_det  = scl_high & ~sda_q_r & sda_in;
  wire       byte_done = (bit_cnt_r == nvm_pkg::BYTE_BITS);
  wire [2:0] sel_pins  = {select_pin_2, select_pin_1, select_pin_0};
  wire       type_ok   = (rx_r[nvm_pkg::TYPE_MSB:nvm_pkg::TYPE_LSB] == TYPE_CODE);
  wire       sel_ok    = (rx_r[nvm_pkg::SEL_MSB:nvm_pkg::SEL_LSB] == sel_pins);
  wire       dev_match = type_ok & sel_ok;
  wire       dir_read  = (rx_r[nvm_pkg::DIR_BIT] == nvm_pkg::DIR_READ);
  wire       wr_allow  = ~write_protect;
  wire [15:0] ptr_inc  = nvm_inc(ptr_r);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    state_nxt     = state_r;
    ret_nxt       = ret_r;
    bit_cnt_nxt   = bit_cnt_r;
    rx_nxt        = rx_r;
    tx_nxt        = tx_r;
    wbuf_nxt      = wbuf_r;
    ptr_nxt       = ptr_r;
    pend_nxt      = pend_r;
    mack_nxt      = mack_r;
    oe_nxt        = oe_r;
    mem_en_nxt    = 1'b0;
    mem_we_nxt    = 1'b0;
    mem_addr_nxt  = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    if (stop_det)
    begin
      state_nxt = nvm_pkg::NVM_IDLE;
      oe_nxt    = 1'b0;
      pend_nxt  = 1'b0;
    end
    else if (start_det)
    begin
      state_nxt   = nvm_pkg::NVM_DEV;
      bit_cnt_nxt = nvm_pkg::BIT_CNT_0;
      oe_nxt      = 1'b0;
      pend_nxt    = 1'b0;
    end
    else
    begin
      case (state_r)
        nvm_pkg::NVM_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        nvm_pkg::NVM_DEV,
        nvm_pkg::NVM_AHI,
        nvm_pkg::NVM_ALO,
        nvm_pkg::NVM_WDAT:
        begin
          if (scl_rise && !byte_done)
          begin
            rx_nxt      = {rx_r[6:0], sda_in};
            bit_cnt_nxt = bit_cnt_r + nvm_pkg::BIT_STEP;
          end
          else if (scl_fall && byte_done)
          begin
            bit_cnt_nxt = nvm_pkg::BIT_CNT_0;
            oe_nxt      = 1'b1;
            state_nxt   = nvm_pkg::NVM_ACK;
            case (state_r)
              nvm_pkg::NVM_DEV:
              begin
                if (dev_match)
                begin
                  oe_nxt = 1'b1;
                  if (dir_read)
                  begin
                    ret_nxt      = nvm_pkg::NVM_RDAT;
                    mem_en_nxt   = 1'b1;
                    mem_addr_nxt = ptr_r;
                  end
                  else
                  begin
                    ret_nxt = nvm_pkg::NVM_AHI;
                  end
                end
                else
                begin
                  oe_nxt    = 1'b0;
                  state_nxt = nvm_pkg::NVM_IDLE;
                end
              end
              nvm_pkg::NVM_AHI:
              begin
                ptr_nxt = {rx_r, ptr_r[7:0]};
                ret_nxt = nvm_pkg::NVM_ALO;
              end
              nvm_pkg::NVM_ALO:
              begin
                ptr_nxt = {ptr_r[15:8], rx_r};
                ret_nxt = nvm_pkg::NVM_WDAT;
              end
              default:
              begin
                wbuf_nxt = rx_r;
                pend_nxt = 1'b1;
                ret_nxt  = nvm_pkg::NVM_WDAT;
              end
            endcase
          end
        end
        nvm_pkg::NVM_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_nxt = nvm_pkg::BIT_CNT_0;
            state_nxt   = ret_r;
            if (ret_r == nvm_pkg::NVM_RDAT)
            begin
              tx_nxt = mem_rdata;
              oe_nxt = ~mem_rdata[7];
            end
            else
            begin
              oe_nxt = 1'b0;
            end
            if (pend_r)
            begin
              mem_en_nxt    = wr_allow;
              mem_we_nxt    = wr_allow;
              mem_addr_nxt  = ptr_r;
              mem_wdata_nxt = wbuf_r;
              ptr_nxt       = ptr_inc;
              pend_nxt      = 1'b0;
            end
          end
        end
        nvm_pkg::NVM_RDAT:
        begin
          if (scl_rise)
          begin
            bit_cnt_nxt = bit_cnt_r + nvm_pkg::BIT_STEP;
          end
          else if (scl_fall)
          begin
            if (byte_done)
            begin
              oe_nxt       = 1'b0;
              state_nxt    = nvm_pkg::NVM_RACK;
              ptr_nxt      = ptr_inc;
              mem_en_nxt   = 1'b1;
              mem_addr_nxt = ptr_inc;
            end
            else
            begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_nxt = ~tx_r[6];
            end
          end
        end
        nvm_pkg::NVM_RACK:
        begin
          if (scl_rise)
          begin
            mack_nxt = sda_in;
          end
          else if (scl_fall)
          begin
            bit_cnt_nxt = nvm_pkg::BIT_CNT_0;
            if (!mack_r)
            begin
              state_nxt = nvm_pkg::NVM_RDAT;
              tx_nxt    = mem_rdata;
              oe_nxt    = ~mem_rdata[7];
            end
            else
            begin
              state_nxt = nvm_pkg::NVM_IDLE;
              oe_nxt    = 1'b0;
            end
          end
        end
        default:
        begin
          state_nxt = nvm_pkg::NVM_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_r   <= nvm_pkg::NVM_IDLE;
      ret_r     <= nvm_pkg::NVM_IDLE;
      bit_cnt_r <= nvm_pkg::BIT_CNT_0;
      oe_r      <= 1'b0;
      pend_r    <= 1'b0;
      mack_r    <= 1'b1;
      scl_q_r   <= 1'b1;
      sda_q_r   <= 1'b1;
      busy_r    <= 1'b0;
      mem_en_r  <= 1'b0;
      mem_we_r  <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      ret_r     <= ret_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      oe_r      <= oe_nxt;
      pend_r    <= pend_nxt;
      mack_r    <= mack_nxt;
      scl_q_r   <= scl_in;
      sda_q_r   <= sda_in;
      busy_r    <= (state_nxt != nvm_pkg::NVM_IDLE);
      mem_en_r  <= mem_en_nxt;
      mem_we_r  <= mem_we_nxt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_r        <= nvm_pkg::BYTE_RST;
      tx_r        <= nvm_pkg::BYTE_RST;
      wbuf_r      <= nvm_pkg::BYTE_RST;
      ptr_r       <= nvm_pkg::PTR_RST;
      mem_addr_r  <= nvm_pkg::PTR_RST;
      mem_wdata_r <= nvm_pkg::BYTE_RST;
    end
    else
    begin
      rx_r        <= rx_nxt;
      tx_r        <= tx_nxt;
      wbuf_r      <= wbuf_nxt;
      ptr_r       <= ptr_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  // ****************************************************************
  // Byte array
  // ****************************************************************
  nvm_mem #(
    .AW (AW),
    .DW (nvm_pkg::BYTE_W)
  ) u_mem (
    .core_clk (core_clk),
    .en       (mem_en_r),
    .we       (mem_we_r),
    .addr     (mem_addr_r[AW-1:0]),
    .wdata    (mem_wdata_r),
    .rdata_r  (mem_rdata)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_oe  = oe_r;
  assign sda_out = 1'b0;
  assign busy    = busy_r;

endmodule

/* nvm_slave_chk.sv */
// Port assertions for the serial byte memory slave.
module nvm_slave_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Serial bus and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence start_cond;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence
  sequence stop_cond;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence

  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda_oe rose with scl high");
  a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("sda_oe fell with scl high");
  a_oe_after_fall: assert property ($rose(sda_oe) |-> !$past(scl_in) && $past(scl_in, 2))
    else $error("sda_oe rose other than just after scl fall");
  a_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda_oe moved while scl high");
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("driven level is not low");
  a_idle_quiet: assert property (!busy |-> !sda_oe)
    else $error("idle device drives sda");
  a_stop_idle: assert property (stop_cond |-> ##[1:3] !busy)
    else $error("stop did not return to idle");
  a_start_busy: assert property (start_cond |-> ##[1:4] busy)
    else $error("start not taken");
endmodule

bind nvm_slave nvm_slave_chk u_nvm_slave_chk (
  .core_clk(core_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy)
);

/* nvm_master.sv */
// Bus master model that drives the serial clock and its side of the data wire.
module nvm_master (
  // Clock
  input  wire logic core_clk,
  // Serial bus
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Waits one third of a bus clock period.
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask

  task automatic start();
    sda_m = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask

  // Data changes only while the clock is low.
  task automatic clk_bit(input logic b, output logic r);
    sda_m = b;
    half();
    scl = 1'b1;
    half();
    r = sda_w;
    scl = 1'b0;
    half();
  endtask

  // Eight bits MSB first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic k);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(d[i], r);
      q[i] = r;
    end
    clk_bit(a, k);
  endtask
endmodule

/* tb_nvm_slave.sv */
// Self-checking testbench for the serial byte memory slave.
module tb_nvm_slave;
  timeunit 1ns;
  timeprecision 1ps;
  // Device type code; the value is arbitrary.
  localparam logic [3:0] TC = 4'h9;
  logic        core_clk;
  logic        srst;
  logic        scl;
  logic        sda_m;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe;
  logic [2:0]  sel;
  logic        wp;
  logic        busy;
  logic        kb;
  logic [7:0]  mem_m [0:65535];
  logic [15:0] ptr;
  logic [15:0] ra;
  logic [31:0] rs;
  int          rn;
  int          n_mismatch;
  int          n_compared;

  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);

  nvm_slave #(.TYPE_CODE(TC)) u_nvm_slave (
    .core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .select_pin_2(sel[2]), .select_pin_1(sel[1]), .select_pin_0(sel[0]),
    .write_protect(wp), .busy(busy)
  );
  nvm_master u_nvm_master (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [7:0] addr_byte(input logic [3:0] t, input logic [2:0] s, input logic rd);
    return {t, s, rd};
  endfunction

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e || $isunknown(s))
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic s);
    n_compared++;
    if (s !== e || $isunknown(s))
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic dev(input logic rd, input logic [3:0] t, input logic [2:0] s, input logic e);
    logic [7:0] q;
    logic       k;
    u_nvm_master.xfer(addr_byte(t, s, rd), 1'b1, q, k);
    chk1("address ack", e, k);
  endtask

  task automatic adr(input logic [15:0] a);
    logic [7:0] q;
    logic       k;
    u_nvm_master.start();
    dev(1'b0, TC, sel, 1'b0);
    u_nvm_master.xfer(a[15:8], 1'b1, q, k);
    chk1("high ack", 1'b0, k);
    u_nvm_master.xfer(a[7:0], 1'b1, q, k);
    chk1("low ack", 1'b0, k);
    ptr = a;
  endtask

  task automatic wr(input logic [15:0] a, input int n);
    logic [7:0] q;
    logic [7:0] d;
    logic       k;
    adr(a);
    for (int i = 0; i < n; i++)
    begin
      d = 8'(rnd());
      u_nvm_master.xfer(d, 1'b1, q, k);
      chk1("data ack", 1'b0, k);
      if (!wp)
        mem_m[ptr] = d;
      ptr = ptr + 16'h0001;
    end
    u_nvm_master.stop();
    chk1("busy", 1'b0, busy);
  endtask

  task automatic rd(input logic cur, input logic [15:0] a, input int n);
    logic [7:0] q;
    logic       k;
    if (!cur)
      adr(a);
    u_nvm_master.start();
    dev(1'b1, TC, sel, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      u_nvm_master.xfer(8'hff, i == n - 1, q, k);
      chk8("read data", mem_m[ptr], q);
      ptr = ptr + 16'h0001;
    end
    u_nvm_master.stop();
  endtask

  initial
  begin
    rs = 32'hfbebe384;
    n_mismatch = 0;
    n_compared = 0;
    srst = 1'b1;
    sel = 3'h5;
    wp = 1'b0;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    repeat (2) @(negedge core_clk);
    wr(16'hfffe, 4);
    rd(1'b0, 16'hfffe, 2);
    rd(1'b1, 16'h0000, 2);
    wp = 1'b1;
    wr(16'hfffe, 4);
    wp = 1'b0;
    rd(1'b0, 16'hfffe, 4);
    for (int s = 1; s < 9; s++)
    begin
      u_nvm_master.start();
      dev(1'b0, (s == 8) ? TC ^ 4'h1 : TC, (s == 8) ? sel : sel ^ 3'(s), 1'b1);
      u_nvm_master.stop();
    end
    wr(16'h1234, 1);
    adr(16'h1234);
    for (int i = 7; i > 0; i--)
      u_nvm_master.clk_bit(~mem_m[16'h1234][i], kb);
    u_nvm_master.stop();
    rd(1'b0, 16'h1234, 1);
    for (int j = 0; j < 16; j++)
    begin
      sel = 3'(rnd());
      wp = 1'b0;
      ra = 16'(rnd());
      rn = 1 + int'(rnd() & 32'h3);
      wr(ra, rn);
      wp = (rnd() & 32'h3) == 32'h0;
      wr(ra, rn);
      rd(1'b0, ra, 1);
      if (rn > 1)
        rd(1'b1, ra, rn - 1);
    end
    close_out();
  end

  initial
  begin
    repeat (80000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end
endmodule
